// ### gpio_port_pin_mux.sv
// five gpio port blocks with pin mux, pad control, interrupts, apb slave
`timescale 1ns/100ps
`include "gpio_defs.svh"
module gpio_port_pin_mux #(
  parameter int ADDR_W = 15
) (
  input  wire logic                clk_sys_i,              // system clock, 40 MHz
  input  wire logic                srst_i,                 // sync reset, active high
  input  wire logic                psel_i,                 // apb select
  input  wire logic                penable_i,              // apb enable
  input  wire logic                pwrite_i,               // apb write
  input  wire logic [ADDR_W-1:0]   paddr_i,                // apb byte address
  input  wire logic [31:0]         pwdata_i,               // apb write data
  output logic                     pready_o,               // apb ready
  output logic                     pslverr_o,              // apb error
  output logic [31:0]              prdata_o,               // apb read data
  input  wire logic [4:0][7:0]     pin_i,                  // pad input level
  output logic [4:0][7:0]          pin_out_o,              // pad output level
  output logic [4:0][7:0]          pin_oe_o,               // pad output enable
  input  wire logic [4:0][7:0][15:0] alt_out_i,            // peripheral out per code
  input  wire logic [4:0][7:0][15:0] alt_oe_i,             // peripheral oe per code
  output logic [4:0][7:0]          alt_in_o,               // pin level to peripherals
  output logic [4:0][7:0]          pull_up_o,              // weak pull-up
  output logic [4:0][7:0]          pull_down_o,            // weak pull-down
  output logic [4:0][7:0]          drive_2ma_o,            // 2 mA drive
  output logic [4:0][7:0]          drive_4ma_o,            // 4 mA drive
  output logic [4:0][7:0]          drive_8ma_o,            // 8 mA drive
  output logic [4:0][7:0]          slew_o,                 // slew control
  output logic [4:0][7:0]          digital_input_enable_o, // input buffer on
  output logic [4:0][7:0]          isolated_analog_input_o, // isolated analog path
  output logic [4:0][7:0]          analog_direct_o,        // direct comparator path
  output logic [4:0]               irq_o,                  // per port interrupt
  output logic                     adc_trigger_o           // converter trigger pulse
);
  localparam int NPORT = `PORT_COUNT;
  localparam logic [39:0]  IMPL_ALL  = `PIN_IMPL;
  localparam logic [39:0]  AF_ALL    = `RST_AFSEL;
  localparam logic [39:0]  DIG_EN_ALL = `RST_DIG_EN;
  localparam logic [39:0]  PUR_ALL   = `RST_PUR;
  localparam logic [39:0]  PDR_ALL   = `RST_PDR;
  localparam logic [39:0]  DR2_ALL   = `RST_DR2;
  localparam logic [159:0] PCTL_ALL  = `RST_PCTL;

  if (ADDR_W < `PORT_SEL_LSB + `PORT_SEL_W) begin : g_chk
    $error("address too narrow for five port windows");
  end

  gpio_pkg::apb_state_s apb_ff;
  gpio_pkg::apb_state_s nxt_apb;

  logic [NPORT-1:0]        hit;
  logic [NPORT-1:0][31:0]  rd_word;
  logic [NPORT-1:0]        trig_vec;
  logic                    setup;
  logic                    wr_acc;
  logic [`PORT_SEL_W-1:0]  port_sel;
  logic [`OFS_W-1:0]       ofs;
  logic                    in_data;
  logic [7:0]              amask;

  assign setup    = psel_i & ~penable_i;
  // write lands on the one access edge that completes a clean transfer
  assign wr_acc   = psel_i & penable_i & apb_ff.ready & pwrite_i & ~apb_ff.slverr;
  assign port_sel = paddr_i[`PORT_SEL_LSB +: `PORT_SEL_W];
  assign ofs      = paddr_i[`OFS_W-1:0];
  assign in_data  = (ofs[`OFS_W-1:10] == 2'h0);
  assign amask    = paddr_i[`MASK_LSB +: 8];

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    localparam logic [7:0] IMPL = IMPL_ALL[8*p +: 8];

    gpio_pkg::port_state_s st_ff;
    gpio_pkg::port_state_s nxt_st;
    logic [7:0]            din;
    logic [7:0]            ris;
    logic [7:0]            mis;
    logic [7:0]            w;
    logic                  we;

    gpio_sync_if #(.W(8)) sif ();
    assign sif.d = pin_i[p];
    gpio_sync2 #(.W(8), .STAGES(2)) u_sync (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .s         (sif.sink)
    );

    assign din = sif.q & st_ff.dig_en & IMPL;
    assign w   = pwdata_i[7:0] & IMPL;
    assign we  = wr_acc & (port_sel == `PORT_SEL_W'(p));
    // level conditions are live, edge conditions sticky until cleared
    assign ris = ((st_ff.sense & (st_ff.event_hi & din | ~st_ff.event_hi & ~din))
                 | (~st_ff.sense & st_ff.edge_flag)) & IMPL & st_ff.dig_en;
    assign mis = ris & st_ff.mask;

    always_comb begin
      logic [7:0]  rise;
      logic [7:0]  fall;
      logic [7:0]  edge_hit;
      logic [7:0]  clr;
      logic [3:0]  code;
      logic        o;
      logic        e;
      rise     = din & ~st_ff.prev;
      fall     = ~din & st_ff.prev;
      edge_hit = (st_ff.both & (rise | fall))
               | (~st_ff.both & ((st_ff.event_hi & rise) | (~st_ff.event_hi & fall)));
      clr      = '0;
      code     = '0;
      o        = 1'b0;
      e        = 1'b0;
      nxt_st   = st_ff;
      nxt_st.prev = din;

      if (we && in_data) begin
        nxt_st.data = (st_ff.data & ~amask) | (w & amask);
      end else if (we) begin
        unique case (ofs)
          `OFS_DIR:    nxt_st.dir      = w;
          `OFS_ISENSE: nxt_st.sense    = w;
          `OFS_IBOTH:  nxt_st.both     = w;
          `OFS_IEVENT: nxt_st.event_hi = w;
          `OFS_IMASK:  nxt_st.mask     = w;
          `OFS_ICLR:   clr             = w;
          `OFS_AFSEL:  nxt_st.afsel    = w;
          // drive strengths exclude each other; leaving 8 mA drops slew
          `OFS_DR2: begin
            nxt_st.dr2 = st_ff.dr2 | w;
            nxt_st.dr4 = st_ff.dr4 & ~w;
            nxt_st.dr8 = st_ff.dr8 & ~w;
            nxt_st.slr = st_ff.slr & ~w;
          end
          `OFS_DR4: begin
            nxt_st.dr4 = st_ff.dr4 | w;
            nxt_st.dr2 = st_ff.dr2 & ~w;
            nxt_st.dr8 = st_ff.dr8 & ~w;
            nxt_st.slr = st_ff.slr & ~w;
          end
          `OFS_DR8: begin
            nxt_st.dr8 = st_ff.dr8 | w;
            nxt_st.dr2 = st_ff.dr2 & ~w;
            nxt_st.dr4 = st_ff.dr4 & ~w;
          end
          `OFS_ODR:    nxt_st.odr      = w;
          `OFS_PUR: begin
            nxt_st.pur = w;
            nxt_st.pdr = st_ff.pdr & ~w;
          end
          `OFS_PDR: begin
            nxt_st.pdr = w;
            nxt_st.pur = st_ff.pur & ~w;
          end
          `OFS_SLR:    nxt_st.slr      = w & st_ff.dr8;
          `OFS_DIG_EN: nxt_st.dig_en   = w;
          `OFS_ANA_SEL: nxt_st.ana_sel = w;
          `OFS_PCTL: begin
            for (int i = 0; i < 8; i++) begin
              nxt_st.pctl[4*i +: 4] = IMPL[i] ? pwdata_i[4*i +: 4] : 4'h0;
            end
          end
          default: ;
        endcase
      end

      // hardware set wins over a same cycle clear
      nxt_st.edge_flag = ((st_ff.edge_flag & ~clr) | (edge_hit & ~st_ff.sense)) & IMPL;

      for (int i = 0; i < 8; i++) begin
        code = st_ff.pctl[4*i +: 4];
        if (st_ff.afsel[i]) begin
          o = alt_out_i[p][i][code];
          e = alt_oe_i[p][i][code];
        end else begin
          o = st_ff.data[i];
          e = st_ff.dir[i];
        end
        e = e & st_ff.dig_en[i] & IMPL[i];
        if (st_ff.odr[i]) begin
          e = e & ~o;
          o = 1'b0;
        end
        nxt_st.pin_out[i] = o;
        nxt_st.pin_oe[i]  = e;
      end

      nxt_st.alt_in = din & st_ff.afsel;
      nxt_st.iso    = ~st_ff.dig_en & st_ff.ana_sel & IMPL;
      nxt_st.direct = ~st_ff.dig_en & IMPL;
      nxt_st.irq    = |mis;
      if (p == `TRIG_PORT) begin
        nxt_st.trig_prev = mis[`TRIG_PIN];
        nxt_st.trig      = mis[`TRIG_PIN] & ~st_ff.trig_prev;
      end else begin
        nxt_st.trig_prev = 1'b0;
        nxt_st.trig      = 1'b0;
      end
    end

    // reset restores every pin to its documented default
    always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
        st_ff       <= '0;
        st_ff.afsel <= AF_ALL[8*p +: 8];
        st_ff.dig_en <= DIG_EN_ALL[8*p +: 8];
        st_ff.pur   <= PUR_ALL[8*p +: 8];
        st_ff.pdr   <= PDR_ALL[8*p +: 8];
        st_ff.dr2   <= DR2_ALL[8*p +: 8];
        st_ff.pctl  <= PCTL_ALL[32*p +: 32];
      end else begin
        st_ff <= nxt_st;
      end
    end

    always_comb begin
      hit[p]     = 1'b1;
      rd_word[p] = '0;
      if (in_data) begin
        rd_word[p][7:0] = ((st_ff.dir & ~st_ff.afsel & st_ff.data)
                          | (~(st_ff.dir & ~st_ff.afsel) & din)) & amask & IMPL;
      end else begin
        unique case (ofs)
          `OFS_DIR:    rd_word[p][7:0] = st_ff.dir;
          `OFS_ISENSE: rd_word[p][7:0] = st_ff.sense;
          `OFS_IBOTH:  rd_word[p][7:0] = st_ff.both;
          `OFS_IEVENT: rd_word[p][7:0] = st_ff.event_hi;
          `OFS_IMASK:  rd_word[p][7:0] = st_ff.mask;
          `OFS_RIS:    rd_word[p][7:0] = ris;
          `OFS_MIS:    rd_word[p][7:0] = mis;
          `OFS_ICLR:   rd_word[p][7:0] = 8'h00;
          `OFS_AFSEL:  rd_word[p][7:0] = st_ff.afsel;
          `OFS_DR2:    rd_word[p][7:0] = st_ff.dr2;
          `OFS_DR4:    rd_word[p][7:0] = st_ff.dr4;
          `OFS_DR8:    rd_word[p][7:0] = st_ff.dr8;
          `OFS_ODR:    rd_word[p][7:0] = st_ff.odr;
          `OFS_PUR:    rd_word[p][7:0] = st_ff.pur;
          `OFS_PDR:    rd_word[p][7:0] = st_ff.pdr;
          `OFS_SLR:    rd_word[p][7:0] = st_ff.slr;
          `OFS_DIG_EN: rd_word[p][7:0] = st_ff.dig_en;
          `OFS_ANA_SEL: rd_word[p][7:0] = st_ff.ana_sel;
          `OFS_PCTL:   rd_word[p]      = st_ff.pctl;
          default:     hit[p]          = 1'b0;
        endcase
      end
    end

    assign pin_out_o[p]               = st_ff.pin_out;
    assign pin_oe_o[p]                = st_ff.pin_oe;
    assign alt_in_o[p]                = st_ff.alt_in;
    assign pull_up_o[p]               = st_ff.pur;
    assign pull_down_o[p]             = st_ff.pdr;
    assign drive_2ma_o[p]             = st_ff.dr2;
    assign drive_4ma_o[p]             = st_ff.dr4;
    assign drive_8ma_o[p]             = st_ff.dr8;
    assign slew_o[p]                  = st_ff.slr;
    assign digital_input_enable_o[p]  = st_ff.dig_en;
    assign isolated_analog_input_o[p] = st_ff.iso;
    assign analog_direct_o[p]         = st_ff.direct;
    assign irq_o[p]                   = st_ff.irq;
    assign trig_vec[p]                = st_ff.trig;
  end

  // one wait-free access phase; answer is formed during setup
  always_comb begin
    logic ok;
    ok      = (port_sel < `PORT_SEL_W'(NPORT));
    nxt_apb = '0;
    if (ok) begin
      ok = hit[port_sel];
    end
    if (ADDR_W > `PORT_SEL_LSB + `PORT_SEL_W) begin
      ok = ok & ~|(paddr_i >> (`PORT_SEL_LSB + `PORT_SEL_W));
    end
    if (setup) begin
      nxt_apb.ready  = 1'b1;
      nxt_apb.slverr = ~ok;
      if (ok && !pwrite_i) begin
        nxt_apb.rdata = rd_word[port_sel];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      apb_ff <= '0;
    end else begin
      apb_ff <= nxt_apb;
    end
  end

  assign pready_o      = apb_ff.ready;
  assign pslverr_o     = apb_ff.slverr;
  assign prdata_o      = apb_ff.rdata;
  // only the trigger port can pulse, so its flop drives the pin directly
  assign adc_trigger_o = trig_vec[`TRIG_PORT];
endmodule

// ### gpio_defs.svh
// register offsets, reset values and sizing constants of the gpio ports
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

`define PORT_COUNT      5
`define PINS_PER_PORT   8
`define PORT_SEL_LSB    12
`define PORT_SEL_W      3
`define OFS_W           12
`define MASK_LSB        2
`define MUX_CODE_W      4
`define MUX_FUNC_COUNT  16

`define OFS_DIR         12'h400
`define OFS_ISENSE      12'h404
`define OFS_IBOTH       12'h408
`define OFS_IEVENT      12'h40C
`define OFS_IMASK       12'h410
`define OFS_RIS         12'h414
`define OFS_MIS         12'h418
`define OFS_ICLR        12'h41C
`define OFS_AFSEL       12'h420
`define OFS_DR2         12'h500
`define OFS_DR4         12'h504
`define OFS_DR8         12'h508
`define OFS_ODR         12'h50C
`define OFS_PUR         12'h510
`define OFS_PDR         12'h514
`define OFS_SLR         12'h518
`define OFS_DIG_EN      12'h51C
`define OFS_ANA_SEL     12'h528
`define OFS_PCTL        12'h52C

// packed per port, port 0 (A) in the low byte, or in the low 32 bits of RST_PCTL
`define PIN_IMPL        40'h03_FF_FF_FF_3F
`define RST_AFSEL       40'h00_00_0F_0C_3F
`define RST_DIG_EN      40'h00_00_0F_0C_3F
`define RST_PUR         40'h00_00_0F_00_00
`define RST_PDR         40'h00_00_00_00_00
`define RST_DR2         40'h03_FF_FF_FF_3F
`define RST_PCTL        160'h00000000_00000000_00003333_00001100_00111111

`define TRIG_PORT       1
`define TRIG_PIN        4

`endif

// ### gpio_pkg.sv
// types shared by the gpio port logic
package gpio_pkg;

  typedef logic [7:0] pin_vec_t;

  typedef struct packed {
    pin_vec_t    data;
    pin_vec_t    dir;
    pin_vec_t    sense;
    pin_vec_t    both;
    pin_vec_t    event_hi;
    pin_vec_t    mask;
    pin_vec_t    edge_flag;
    pin_vec_t    afsel;
    pin_vec_t    dr2;
    pin_vec_t    dr4;
    pin_vec_t    dr8;
    pin_vec_t    odr;
    pin_vec_t    pur;
    pin_vec_t    pdr;
    pin_vec_t    slr;
    pin_vec_t    dig_en;
    pin_vec_t    ana_sel;
    logic [31:0] pctl;
    pin_vec_t    prev;
    pin_vec_t    pin_out;
    pin_vec_t    pin_oe;
    pin_vec_t    alt_in;
    pin_vec_t    iso;
    pin_vec_t    direct;
    logic        irq;
    logic        trig_prev;
    logic        trig;
  } port_state_s;

  typedef struct packed {
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } apb_state_s;

endpackage

// ### gpio_sync_if.sv
// carrier between a port and its pin synchroniser
`timescale 1ns/100ps
interface gpio_sync_if #(parameter int W = 8);
  logic [W-1:0] d;
  logic [W-1:0] q;
  modport sink (input d, output q);
  modport src  (output d, input q);
endinterface

// ### gpio_sync2.sv
// two flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module gpio_sync2 #(
  parameter int W      = 8,
  parameter int STAGES = 2
) (
  input  wire logic  clk_sys_i, // system clock
  input  wire logic  srst_i,    // sync reset, active high
  gpio_sync_if.sink  s          // raw levels in, synced out
);
  typedef struct packed {
    logic [STAGES-1:0][W-1:0] stg;
  } sync_state_s;

  sync_state_s st_ff;
  sync_state_s nxt_st;

  if (STAGES < 2 || W < 1) begin : g_chk
    $error("gpio_sync2 needs at least two stages and one bit");
  end

  // first stage feeds only the second
  always_comb begin
    nxt_st = st_ff;
    nxt_st.stg = {st_ff.stg[STAGES-2:0], s.d};
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s.q = st_ff.stg[STAGES-1];
endmodule

// ### gpio_pin_model.sv
// pad and external circuit model seen by the gpio pins
`timescale 1ns/100ps
module gpio_pin_model (
  input  wire logic            clk_sys_i,   // system clock
  input  wire logic [4:0][7:0] pin_out_i,   // pad drive level
  input  wire logic [4:0][7:0] pin_oe_i,    // pad drive enable
  input  wire logic [4:0][7:0] pull_up_i,   // weak pull-up
  input  wire logic [4:0][7:0] pull_down_i, // weak pull-down
  input  wire logic [4:0][7:0] ext_en_i,    // external source drives
  input  wire logic [4:0][7:0] ext_val_i,   // external source level
  output logic      [4:0][7:0] pin_o        // resolved pad level
);
  logic [4:0][7:0] flip = '0;
  // floating pins toggle so a stale level never looks valid
  always @(posedge clk_sys_i) flip <= ~flip;
  assign pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ((ext_en_i & ext_val_i)
               | (~ext_en_i & (pull_up_i | (~pull_down_i & flip)))));
endmodule

// ### gpio_port_pin_mux_checker.sv
// concurrent checks on the gpio block ports
`timescale 1ns/100ps
`include "gpio_defs.svh"
module gpio_port_pin_mux_checker (
  input wire logic            clk_sys_i,               // clock
  input wire logic            srst_i,                  // reset
  input wire logic            psel_i,                  // select
  input wire logic            penable_i,               // enable
  input wire logic            pwrite_i,                // write
  input wire logic            pready_o,                // ready
  input wire logic            pslverr_o,               // error
  input wire logic [31:0]     prdata_o,                // read data
  input wire logic [4:0][7:0] pin_oe_o,                // pad oe
  input wire logic [4:0][7:0] pull_up_o,               // pull-up
  input wire logic [4:0][7:0] pull_down_o,             // pull-down
  input wire logic [4:0][7:0] drive_2ma_o,             // 2 mA
  input wire logic [4:0][7:0] drive_4ma_o,             // 4 mA
  input wire logic [4:0][7:0] drive_8ma_o,             // 8 mA
  input wire logic [4:0][7:0] slew_o,                  // slew
  input wire logic [4:0][7:0] digital_input_enable_o,  // input buffer
  input wire logic [4:0][7:0] isolated_analog_input_o, // isolated path
  input wire logic [4:0][7:0] analog_direct_o,         // direct path
  input wire logic [4:0]      irq_o,                   // port irq
  input wire logic            adc_trigger_o            // trigger
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_answer; pready_o ##1 !pready_o; endsequence
  property p_answer; s_setup |=> s_answer; endproperty
  a_answer: assert property (p_answer) else $error("apb answer wrong");
  property p_err; pslverr_o |-> pready_o && prdata_o == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error with data");
  property p_wzero; pready_o && pwrite_i |-> prdata_o == 32'h0; endproperty
  a_wzero: assert property (p_wzero) else $error("write returned data");
  property p_rst;
    @(posedge clk_sys_i) disable iff (1'b0) srst_i |=> pull_up_o == `RST_PUR
      && pull_down_o == `RST_PDR && digital_input_enable_o == `RST_DIG_EN
      && drive_2ma_o == `RST_DR2 && pin_oe_o == '0 && irq_o == '0 && !adc_trigger_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_iso; (isolated_analog_input_o & ~analog_direct_o) == '0; endproperty
  a_iso: assert property (p_iso) else $error("isolated path with input on");
  property p_slew; (slew_o & ~drive_8ma_o) == '0; endproperty
  a_slew: assert property (p_slew) else $error("slew without 8 mA");
  property p_drive;
    ((drive_2ma_o & drive_4ma_o) | (drive_2ma_o & drive_8ma_o) | (drive_4ma_o & drive_8ma_o)) == '0;
  endproperty
  a_drive: assert property (p_drive) else $error("two drive strengths");
  property p_pull; (pull_up_o & pull_down_o) == '0; endproperty
  a_pull: assert property (p_pull) else $error("both pulls on");
  property p_trig; adc_trigger_o |-> irq_o[1] ##1 !adc_trigger_o; endproperty
  a_trig: assert property (p_trig) else $error("trigger not a pulse with irq");
endmodule

// ### gpio_port_pin_mux_tb.sv
// self-checking bench for the gpio block
`timescale 1ns/100ps
`include "gpio_defs.svh"
module gpio_port_pin_mux_tb;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [14:0]            paddr_i = '0;
  logic [31:0]            pwdata_i = '0, prdata_o, rdat, seed = 32'hD4A09D9B;
  logic                   pready_o, pslverr_o, adc_trigger_o, rerr;
  logic [4:0][7:0]        pin_i, pin_out_o, pin_oe_o, alt_in_o, pull_up_o, pull_down_o;
  logic [4:0][7:0]        drive_2ma_o, drive_4ma_o, drive_8ma_o, slew_o, analog_direct_o;
  logic [4:0][7:0]        digital_input_enable_o, isolated_analog_input_o;
  logic [4:0][7:0]        ext_en = '0, ext_val = '0;
  logic [4:0][7:0][15:0]  alt_out_i = '0, alt_oe_i = '0;
  logic [4:0]             irq_o;
  int                     errors = 0, n_checks = 0, trig_n = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (adc_trigger_o === 1'b1) trig_n <= trig_n + 1;
  gpio_port_pin_mux u_dut (.clk_sys_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pready_o, .pslverr_o, .prdata_o, .pin_i, .pin_out_o, .pin_oe_o, .alt_out_i,
    .alt_oe_i, .alt_in_o, .pull_up_o, .pull_down_o, .drive_2ma_o, .drive_4ma_o,
    .drive_8ma_o, .slew_o, .digital_input_enable_o, .isolated_analog_input_o,
    .analog_direct_o, .irq_o, .adc_trigger_o);
  gpio_pin_model u_pins (.clk_sys_i, .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
    .pull_up_i(pull_up_o), .pull_down_i(pull_down_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pin_o(pin_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic apb(input logic w, input int p, input logic [11:0] o, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, p[2:0], o, d};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rdat = prdata_o;
    rerr = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic do_reset();
    srst_i <= 1'b1;
    tick(20);
    srst_i <= 1'b0;
  endtask
  initial begin
    logic [39:0] rv [5];
    logic [11:0] ro [5];
    logic [2:0]  md [5];
    logic [159:0] pc;
    logic [7:0]  m, dm, dv;
    logic        fl, pm, lv;
    int          te;
    rv = '{`RST_AFSEL, `RST_DIG_EN, `RST_PUR, `RST_PDR, `RST_DR2};
    ro = '{`OFS_AFSEL, `OFS_DIG_EN, `OFS_PUR, `OFS_PDR, `OFS_DR2};
    md = '{3'b001, 3'b000, 3'b010, 3'b101, 3'b100};
    pc = `RST_PCTL;
    do_reset();
    for (int p = 0; p < 5; p++) begin
      for (int r = 0; r < 5; r++) begin
        apb(1'b0, p, ro[r], 32'h0);
        chk(rdat, {24'h0, rv[r][8*p +: 8]});
      end
      apb(1'b0, p, `OFS_PCTL, 32'h0);
      chk(rdat, pc[32*p +: 32]);
    end
    apb(1'b0, 5, 12'h000, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    // data port D as outputs with address masked access
    apb(1'b1, 3, `OFS_DIR, 32'hFF);
    apb(1'b1, 3, `OFS_DIG_EN, 32'hFF);
    apb(1'b1, 3, 12'h3FC, 32'h0);
    dm = 8'h00;
    for (int i = 0; i < 16; i++) begin
      m = 8'(rnd());
      dv = 8'(rnd());
      apb(1'b1, 3, {2'b00, m, 2'b00}, {24'h0, dv});
      dm = (dm & ~m) | (dv & m);
      m = 8'(rnd());
      apb(1'b0, 3, {2'b00, m, 2'b00}, 32'h0);
      chk(rdat, {24'h0, dm & m});
      chk(32'(pin_out_o[3]), 32'(dm));
    end
    chk(32'(pin_oe_o[3]), 32'hFF);
    // open drain only ever pulls low
    apb(1'b1, 3, `OFS_ODR, 32'hFF);
    tick(2);
    chk({24'h0, pin_oe_o[3]}, {24'h0, ~dm});
    chk({24'h0, pin_out_o[3]}, 32'h0);
    // port B pin 4 interrupt modes and converter trigger
    apb(1'b1, 1, `OFS_DIG_EN, 32'hFF);
    apb(1'b1, 1, `OFS_AFSEL, 32'h0);
    ext_en[1][4] <= 1'b1;
    te = trig_n;
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, 1, `OFS_IMASK, 32'h0);
      apb(1'b1, 1, `OFS_ISENSE, 32'(md[k][2]) << 4);
      apb(1'b1, 1, `OFS_IBOTH, 32'(md[k][1]) << 4);
      apb(1'b1, 1, `OFS_IEVENT, 32'(md[k][0]) << 4);
      ext_val[1][4] <= 1'b0;
      tick(6);
      apb(1'b1, 1, `OFS_ICLR, 32'hFF);
      fl = md[k][2] & ~md[k][0];
      chk(32'(irq_o[1]), 32'h0);
      apb(1'b1, 1, `OFS_IMASK, 32'h10);
      te += fl;
      tick(3);
      chk(32'(irq_o[1]), 32'(fl));
      for (int j = 0; j < 2; j++) begin
        lv = (j == 0);
        ext_val[1][4] <= lv;
        tick(6);
        pm = fl;
        fl = md[k][2] ? (lv == md[k][0]) : (fl | md[k][1] | (lv == md[k][0]));
        te += (!pm && fl);
        apb(1'b0, 1, `OFS_MIS, 32'h0);
        chk(rdat, 32'(fl) << 4);
        chk(32'(irq_o[1]), 32'(fl));
        chk(trig_n, te);
      end
    end
    // alternate function on port A pin 0 for every mux code
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 0, `OFS_PCTL, {28'h0011111, c[3:0]});
      alt_out_i <= {20{rnd()}};
      alt_oe_i <= {20{rnd()}};
      tick(6);
      chk(32'(pin_oe_o[0][0]), 32'(alt_oe_i[0][0][c]));
      if (alt_oe_i[0][0][c]) begin
        chk(32'(pin_out_o[0][0]), 32'(alt_out_i[0][0][c]));
        chk(32'(alt_in_o[0][0]), 32'(alt_out_i[0][0][c]));
      end
    end
    apb(1'b1, 0, `OFS_AFSEL, 32'h3E);
    tick(3);
    chk(32'(pin_oe_o[0][0]), 32'h0);
    // pad and analog settings on port E
    apb(1'b1, 4, `OFS_DR8, 32'h3);
    apb(1'b1, 4, `OFS_SLR, 32'h3);
    apb(1'b0, 4, `OFS_SLR, 32'h0);
    chk(rdat, 32'h3);
    apb(1'b1, 4, `OFS_DR2, 32'h1);
    apb(1'b0, 4, `OFS_DR8, 32'h0);
    chk(rdat, 32'h2);
    apb(1'b0, 4, `OFS_SLR, 32'h0);
    chk(rdat, 32'h2);
    apb(1'b1, 4, `OFS_PUR, 32'h3);
    apb(1'b1, 4, `OFS_PDR, 32'h1);
    apb(1'b0, 4, `OFS_PUR, 32'h0);
    chk(rdat, 32'h2);
    apb(1'b1, 4, `OFS_DIG_EN, 32'h2);
    apb(1'b1, 4, `OFS_ANA_SEL, 32'h3);
    tick(3);
    chk(32'(drive_2ma_o[4] & 8'h03), 32'h1);
    chk(32'(pull_down_o[4] & 8'h03), 32'h1);
    chk(32'(isolated_analog_input_o[4] & 8'h03), 32'h1);
    chk(32'(analog_direct_o[4] & 8'h03), 32'h1);
    // second reset in mid-run restores defaults
    apb(1'b1, 2, `OFS_PUR, 32'h0);
    do_reset();
    apb(1'b0, 2, `OFS_PUR, 32'h0);
    chk(rdat, 32'h0F);
    end_of_test();
  end
  initial begin
    #500000;
    errors++;
    end_of_test();
  end
endmodule
bind gpio_port_pin_mux gpio_port_pin_mux_checker u_chk (.clk_sys_i, .srst_i, .psel_i,
  .penable_i, .pwrite_i, .pready_o, .pslverr_o, .prdata_o, .pin_oe_o, .pull_up_o,
  .pull_down_o, .drive_2ma_o, .drive_4ma_o, .drive_8ma_o, .slew_o,
  .digital_input_enable_o, .isolated_analog_input_o, .analog_direct_o, .irq_o,
  .adc_trigger_o);
